// file: flash_seq_consts.vh
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// opcodes and command sequence bytes
`define OP_SECTOR_ERASE      8'h7C
`define OP_PROG_THRU_BUF     8'h82
`define CHIP_ERASE_WORD      32'hC794_809A
`define PROT_PREFIX          24'h3D2A_7F
`define PROT_ENABLE_BYTE     8'hA9
`define PROT_DISABLE_BYTE    8'h9A

// protection register encoding
`define PROT_BYTE_ON         8'hFF
`define PROT_PAIR_ON         2'h3
`define PROT_0A_HI           7
`define PROT_0B_HI           5

// buffer sizes
`define BUF_SIZE_STD         264
`define BUF_SIZE_BIN         256
`define BUF_LAST_STD         9'h107
`define BUF_LAST_BIN         9'h0FF

// timing, times in microseconds, clock in MHz
`define CLK_MHZ              100
`define SECTOR_ERASE_TIME_US 1000000
`define CHIP_ERASE_TIME_US   4000000
`define PAGE_PROG_TIME_US    40000
`define SECTOR_ERASE_CYCLES  (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define CHIP_ERASE_CYCLES    (`CHIP_ERASE_TIME_US * `CLK_MHZ)
`define PAGE_PROG_CYCLES     (`PAGE_PROG_TIME_US * `CLK_MHZ)

`endif

// file: flash_erase_program_protect_seq.v
// Behaviour
// - std mode small sector erase, 7CH, PA9-PA3
// - std mode big sector erase, 7CH, PA9-PA7
// - binary mode small sector erase, A17-A11
// - binary mode big sector erase, A17-A15
// - sector from top page bits, bit3 splits 0
// - one sector erased per command
// - sector erase starts on cs rise, busy
// - chip erase only from C7 94 80 9A
// - bytes after chip erase bytes ignored
// - chip erase starts on cs release, busy
// - chip erase skips protected or locked sectors
// - write protect deferred until erase completes
// - std program, 82H, 10 page, 9 offset
// - binary program, 82H, 10 page, 8 offset
// - data bytes fill buffer, wrap to zero
// - cs rise erases then programs page, busy
// - 3D 2A 7F A9 enables protection
// - 3D 2A 7F 9A disables unless write protect low
// - software protection off after power up
// - status shows protection enabled, either method
// - FFH byte protects sector, 00H not
// - write protect alone enables protection
`include "flash_seq_consts.vh"

module flash_erase_program_protect_seq #(
  parameter BUF_DEPTH           = `BUF_SIZE_STD,
  parameter SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES,
  parameter CHIP_ERASE_CYCLES   = `CHIP_ERASE_CYCLES,
  parameter PAGE_PROG_CYCLES    = `PAGE_PROG_CYCLES
) (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST,
  // serial command pins
  input  wire        CS_N,
  input  wire        SCK,
  input  wire        SI,
  input  wire        WP_N,
  // configuration
  input  wire        PAGE_256,
  input  wire [63:0] PROT_REG,
  input  wire [8:0]  LOCKED,
  // status
  output reg         BUSY,
  output reg         PROT_ENABLED,
  // array control
  output reg         ERASE_START,
  output reg  [8:0]  ERASE_MASK,
  output reg         PROG_START,
  output reg  [9:0]  PROG_PAGE,
  // buffer readout for the array programmer
  input  wire [8:0]  BUF_RADDR,
  output reg  [7:0]  BUF_RDATA
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  // pin synchronisers, third stage only for edge finding
  reg        cs_s1;
  reg        cs_s2;
  reg        cs_s3;
  reg        sck_s1;
  reg        sck_s2;
  reg        sck_s3;
  reg        si_s1;
  reg        si_s2;
  reg        wp_s1;
  reg        wp_s2;

  reg  [2:0]  bit_cnt;
  reg  [2:0]  byte_cnt;
  reg  [6:0]  shift;
  reg  [31:0] cmd_word;
  reg  [8:0]  wr_ptr;
  reg  [7:0]  buf_mem [0:BUF_DEPTH-1];
  reg  [1:0]  state;
  reg  [31:0] timer;
  reg         sw_prot;
  reg         hw_prot;

  wire        sck_rise;
  wire        cs_rise;
  wire        cs_fall;
  wire        byte_done;
  wire [7:0]  byte_val;
  wire [8:0]  buf_last;
  wire [7:0]  opcode;
  wire [9:0]  page;
  wire [8:0]  target;
  wire [8:0]  sect_spec;
  wire [8:0]  sect_prot;
  wire        whole_cmd;
  wire        idle;
  wire [8:0]  start_offset;
  wire        prot_on;
  wire        target_free;
  wire        launch;
  wire        cmd_chip_erase;
  wire        cmd_sector_erase;
  wire        cmd_program;
  wire        cmd_prot_enable;
  wire        cmd_prot_disable;
  wire        data_byte;
  reg  [8:0]  next_wr_ptr;

  assign sck_rise  = sck_s2 & ~sck_s3;
  assign cs_rise   = cs_s2 & ~cs_s3;
  assign cs_fall   = ~cs_s2 & cs_s3;
  assign byte_done = sck_rise & ~cs_s2 & (bit_cnt == 3'd7);
  assign byte_val  = {shift, si_s2};
  assign buf_last  = PAGE_256 ? `BUF_LAST_BIN : `BUF_LAST_STD;
  assign opcode    = cmd_word[31:24];
  assign idle      = (state == ST_IDLE);
  assign whole_cmd = (byte_cnt == 3'd4) & (bit_cnt == 3'd0);
  assign prot_on   = sw_prot | hw_prot;

  // page bits sit one place higher in the 264-byte mode
  assign page = PAGE_256 ? cmd_word[17:8] : cmd_word[18:9];

  // the offset is loaded while its last byte is still in the shifter
  assign start_offset = PAGE_256 ? {1'b0, byte_val} : {cmd_word[0], byte_val};

  // index 0 is sector 0a, 1 is 0b, 2..8 are sectors 1..7
  function [8:0] sector_of;
    input [9:0] pg;
    begin
      sector_of = 9'h000;
      if (pg[9:7] == 3'd0)
        sector_of[pg[3]] = 1'b1;
      else
        sector_of[{1'b0, pg[9:7]} + 4'd1] = 1'b1;
    end
  endfunction

  assign target = sector_of(page);

  assign sect_spec[0] = PROT_REG[`PROT_0A_HI -: 2] == `PROT_PAIR_ON;
  assign sect_spec[1] = PROT_REG[`PROT_0B_HI -: 2] == `PROT_PAIR_ON;

  genvar k;
  generate
    for (k = 1; k < 8; k = k + 1)
    begin : g_spec
      assign sect_spec[k+1] = PROT_REG[8*k+7 -: 8] == `PROT_BYTE_ON;
    end
  endgenerate

  assign sect_prot = LOCKED | (prot_on ? sect_spec : 9'h000);

  // commands act only on a whole command seen as chip select rises while idle
  assign launch           = cs_rise & whole_cmd & idle;
  // a protected target drops the command outright, so busy never shows for it
  assign target_free      = ~|(target & sect_prot);
  assign cmd_chip_erase   = (cmd_word == `CHIP_ERASE_WORD);
  assign cmd_sector_erase = (opcode == `OP_SECTOR_ERASE) & target_free;
  assign cmd_program      = (opcode == `OP_PROG_THRU_BUF) & target_free;
  assign cmd_prot_enable  = (cmd_word == {`PROT_PREFIX, `PROT_ENABLE_BYTE});
  assign cmd_prot_disable = (cmd_word == {`PROT_PREFIX, `PROT_DISABLE_BYTE}) & wp_s2;
  assign data_byte        = byte_done & (byte_cnt == 3'd4) & idle &
                            (opcode == `OP_PROG_THRU_BUF);

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
      wp_s1  <= 1'b1;
      wp_s2  <= 1'b1;
    end
    else
    begin
      cs_s1  <= CS_N;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      sck_s1 <= SCK;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1  <= SI;
      si_s2  <= si_s1;
      wp_s1  <= WP_N;
      wp_s2  <= wp_s1;
    end
  end

  // serial deserialiser, mode 0 and 3, input taken on sck rise
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
      shift    <= 7'h00;
      cmd_word <= 32'h0000_0000;
    end
    else if (cs_fall)
    begin
      bit_cnt  <= 3'd0;
      byte_cnt <= 3'd0;
    end
    else if (sck_rise & ~cs_s2)
    begin
      bit_cnt <= bit_cnt + 3'd1;
      shift   <= {shift[5:0], si_s2};
      if (byte_done & (byte_cnt != 3'd4))
      begin
        cmd_word <= {cmd_word[23:0], byte_val};
        byte_cnt <= byte_cnt + 3'd1;
      end
    end
  end

  // an offset past the buffer end falls back to zero after one byte
  always @*
  begin
    next_wr_ptr = wr_ptr + 9'h001;
    if (wr_ptr >= buf_last)
      next_wr_ptr = 9'h000;
  end

  // buffer fill, only while a program command is streaming data
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      wr_ptr <= 9'h000;
    else if (byte_done & (byte_cnt == 3'd3))
      wr_ptr <= start_offset;
    else if (data_byte)
      wr_ptr <= next_wr_ptr;
  end

  // storage has no reset; its contents are undefined until written
  always @(posedge REF_CLK)
  begin
    if (data_byte)
      buf_mem[wr_ptr] <= byte_val;
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      BUF_RDATA <= 8'h00;
    else
      BUF_RDATA <= buf_mem[BUF_RADDR];
  end

  // write protect only takes effect between operations
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      hw_prot <= 1'b0;
    else if (idle)
      hw_prot <= ~wp_s2;
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      PROT_ENABLED <= 1'b0;
    else
      PROT_ENABLED <= prot_on;
  end

  // command launch on chip-select release, ignored while busy
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state       <= ST_IDLE;
      timer       <= 32'h0000_0000;
      sw_prot     <= 1'b0;
      BUSY        <= 1'b0;
      ERASE_START <= 1'b0;
      ERASE_MASK  <= 9'h000;
      PROG_START  <= 1'b0;
      PROG_PAGE   <= 10'h000;
    end
    else
    begin
      ERASE_START <= 1'b0;
      PROG_START  <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (launch)
          begin
            if (cmd_chip_erase)
            begin
              ERASE_START <= 1'b1;
              ERASE_MASK  <= ~sect_prot;
              timer       <= CHIP_ERASE_CYCLES;
              BUSY        <= 1'b1;
              state       <= ST_RUN;
            end
            else if (cmd_sector_erase)
            begin
              ERASE_START <= 1'b1;
              ERASE_MASK  <= target;
              timer       <= SECTOR_ERASE_CYCLES;
              BUSY        <= 1'b1;
              state       <= ST_RUN;
            end
            else if (cmd_program)
            begin
              PROG_START <= 1'b1;
              PROG_PAGE  <= page;
              timer      <= PAGE_PROG_CYCLES;
              BUSY       <= 1'b1;
              state      <= ST_RUN;
            end
            else if (cmd_prot_enable)
              sw_prot <= 1'b1;
            else if (cmd_prot_disable)
              sw_prot <= 1'b0;
          end
        end
        ST_RUN:
        begin
          if (timer <= 32'h0000_0001)
          begin
            timer <= 32'h0000_0000;
            BUSY  <= 1'b0;
            state <= ST_IDLE;
          end
          else
            timer <= timer - 32'h0000_0001;
        end
        default:
        begin
          state <= ST_IDLE;
          BUSY  <= 1'b0;
        end
      endcase
    end
  end

endmodule // flash_erase_program_protect_seq

// file: flash_seq_assertions.sv
module flash_seq_checker (
  // clock and reset
  input logic       REF_CLK,
  input logic       RST,
  // pins
  input logic       CS_N,
  input logic       WP_N,
  // status and array control
  input logic       BUSY,
  input logic       PROT_ENABLED,
  input logic       ERASE_START,
  input logic [8:0] ERASE_MASK,
  input logic       PROG_START,
  input logic [9:0] PROG_PAGE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_erase_busy: assert property (ERASE_START |-> BUSY [*8])
    else $error("erase start without busy");
  chk_prog_busy: assert property (PROG_START |-> BUSY [*8])
    else $error("program start without busy");
  chk_start_idle: assert property ((ERASE_START || PROG_START) |->
    !$past(BUSY) && CS_N && $past(CS_N, 2))
    else $error("start while busy or selected");
  chk_one_pulse: assert property (ERASE_START |=> !ERASE_START && !PROG_START)
    else $error("erase start longer than one cycle");
  chk_mask_hold: assert property ($changed(ERASE_MASK) |-> ERASE_START)
    else $error("erase mask moved without start");
  chk_page_hold: assert property ($changed(PROG_PAGE) |-> PROG_START)
    else $error("program page moved without start");
  chk_busy_cause: assert property ($rose(BUSY) |-> ERASE_START || PROG_START)
    else $error("busy without a start");
  chk_wp_defer: assert property (BUSY && $past(BUSY) && $past(BUSY, 2) |->
    $stable(PROT_ENABLED))
    else $error("protection changed mid operation");
  chk_prot_fall: assert property ($fell(PROT_ENABLED) |-> WP_N && $past(WP_N, 2))
    else $error("protection dropped while write protect low");
endmodule // flash_seq_checker

bind flash_erase_program_protect_seq flash_seq_checker chk (.REF_CLK(REF_CLK), .RST(RST),
  .CS_N(CS_N), .WP_N(WP_N), .BUSY(BUSY), .PROT_ENABLED(PROT_ENABLED),
  .ERASE_START(ERASE_START), .ERASE_MASK(ERASE_MASK), .PROG_START(PROG_START),
  .PROG_PAGE(PROG_PAGE));

// file: flash_host_model.sv
module flash_host_model (
  // serial command pins
  output logic CS_N,
  output logic SCK,
  output logic SI
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    CS_N = 1'h1;
    SCK  = 1'h0;
    SI   = 1'h0;
  end
  // mode 0: clock parks low between frames, data shows junk when deselected
  task automatic frame(input logic [31:0] w, input int extra, input logic [7:0] first);
    logic [7:0] b;
    #2;
    CS_N = 1'h0;
    for (int i = 0; i < 4 + extra; i++)
    begin
      b = (i < 4) ? w[31 - 8 * i -: 8] : first + 8'(i - 4);
      for (int k = 7; k >= 0; k--)
      begin
        SI = b[k];
        #62.5 SCK = 1'h1;
        #62.5 SCK = 1'h0;
      end
    end
    #62.5 CS_N = 1'h1;
    SI = ~SI;
    #250;
  endtask
endmodule // flash_host_model

// file: flash_erase_program_protect_seq_test.sv
`include "flash_seq_consts.vh"
module flash_erase_program_protect_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] w; logic m; int x; int ne; int np; logic [9:0] v;
    logic [8:0] a; logic [7:0] f;} row_t;
  logic        ref_clk, rst, cs_n, sck, si, wp_n, page_256, busy, prot_enabled;
  logic        erase_start, prog_start;
  logic [63:0] prot_reg;
  logic [8:0]  locked, erase_mask, buf_raddr;
  logic [9:0]  prog_page;
  logic [7:0]  buf_rdata;
  int          errors, num_checks, n_er, n_pg, e0, p0;
  row_t rows [10] = '{
    '{32'h7C00_0A00, 1'h0, 0, 1, 0, 10'h001, 9'h000, 8'h00},
    '{32'h7C00_1000, 1'h0, 0, 1, 0, 10'h002, 9'h000, 8'h00},
    '{32'h7C03_0000, 1'h0, 0, 1, 0, 10'h010, 9'h000, 8'h00},
    '{32'h7C00_0200, 1'h1, 0, 1, 0, 10'h001, 9'h000, 8'h00},
    '{32'h7C00_0F00, 1'h1, 0, 1, 0, 10'h002, 9'h000, 8'h00},
    '{32'h7CFF_FFFF, 1'h1, 0, 1, 0, 10'h100, 9'h000, 8'h00},
    '{32'hC794_809A, 1'h1, 2, 1, 0, 10'h1FB, 9'h000, 8'h00},
    '{32'hC794_809B, 1'h1, 0, 0, 0, 10'h000, 9'h000, 8'h00},
    '{32'h8205_4B07, 1'h0, 2, 0, 1, 10'h2A5, 9'h000, 8'h5A},
    '{32'h8201_3CFE, 1'h1, 3, 0, 1, 10'h13C, 9'h000, 8'h10}};

  flash_erase_program_protect_seq #(.SECTOR_ERASE_CYCLES(20), .CHIP_ERASE_CYCLES(600),
    .PAGE_PROG_CYCLES(30)) dut (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .SCK(sck),
    .SI(si), .WP_N(wp_n), .PAGE_256(page_256), .PROT_REG(prot_reg), .LOCKED(locked),
    .BUSY(busy), .PROT_ENABLED(prot_enabled), .ERASE_START(erase_start),
    .ERASE_MASK(erase_mask), .PROG_START(prog_start), .PROG_PAGE(prog_page),
    .BUF_RADDR(buf_raddr), .BUF_RDATA(buf_rdata));
  flash_host_model host (.CS_N(cs_n), .SCK(sck), .SI(si));

  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_er = n_er + int'(erase_start);
    n_pg = n_pg + int'(prog_start);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 2000 && busy !== 1'h0; n++)
      tick(1);
    chk_flag(busy, 1'h0);
  endtask
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 200 us
  initial
  begin
    #900us;
    errors++;
    wrap_up();
  end

  initial
  begin
    {rst, wp_n, page_256, prot_reg, locked} = {1'h1, 1'h1, 1'h0, 64'h0, 9'h004};
    buf_raddr = 9'h000;
    tick(6);
    chk_flag(busy, 1'h0);
    chk_val({1'h0, erase_mask}, 10'h000);
    chk_flag(prot_enabled, 1'h0);
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    tick(5);
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      page_256 <= rows[i].m;
      e0 = n_er;
      p0 = n_pg;
      host.frame(rows[i].w, rows[i].x, rows[i].f);
      tick(10);
      chk_val(10'(n_er - e0), 10'(rows[i].ne));
      chk_val(10'(n_pg - p0), 10'(rows[i].np));
      if (rows[i].ne > 0)
        chk_val({1'h0, erase_mask}, rows[i].v);
      if (rows[i].np > 0)
      begin
        chk_val(prog_page, rows[i].v);
        @(posedge ref_clk);
        buf_raddr <= rows[i].a;
        tick(2);
        chk_val({2'h0, buf_rdata}, {2'h0, rows[i].f + 8'(rows[i].x - 1)});
      end
      wait_idle();
    end
    @(posedge ref_clk);
    prot_reg <= 64'h0000_0000_FF00_0000;
    host.frame(`CHIP_ERASE_WORD, 0, 8'h00);
    @(posedge ref_clk);
    wp_n <= 1'h0;
    e0 = n_er;
    host.frame(32'h7CFF_FFFF, 0, 8'h00);
    tick(1);
    chk_val(10'(n_er - e0), 10'h000);
    chk_flag(prot_enabled, 1'h0);
    wait_idle();
    tick(5);
    chk_flag(prot_enabled, 1'h1);
    host.frame({`PROT_PREFIX, `PROT_DISABLE_BYTE}, 0, 8'h00);
    e0 = n_er;
    host.frame(32'h7C01_8000, 0, 8'h00);
    chk_flag(prot_enabled, 1'h1);
    chk_val(10'(n_er - e0), 10'h000);
    @(posedge ref_clk);
    wp_n <= 1'h1;
    tick(6);
    chk_flag(prot_enabled, 1'h0);
    host.frame({`PROT_PREFIX, `PROT_ENABLE_BYTE}, 0, 8'h00);
    chk_flag(prot_enabled, 1'h1);
    host.frame(`CHIP_ERASE_WORD, 0, 8'h00);
    chk_val({1'h0, erase_mask}, 10'h1EB);
    wait_idle();
    @(posedge ref_clk);
    prot_reg <= 64'h0000_0000_FF00_00C0;
    e0 = n_er;
    p0 = n_pg;
    host.frame(32'h7C00_0200, 0, 8'h00);
    host.frame(32'h8201_8000, 1, 8'h33);
    chk_val(10'(n_er - e0), 10'h000);
    chk_val(10'(n_pg - p0), 10'h000);
    host.frame(32'h7C00_0F00, 0, 8'h00);
    chk_val(10'(n_er - e0), 10'h001);
    chk_val({1'h0, erase_mask}, 10'h002);
    wait_idle();
    host.frame({`PROT_PREFIX, `PROT_DISABLE_BYTE}, 0, 8'h00);
    chk_flag(prot_enabled, 1'h0);
    host.frame({`PROT_PREFIX, `PROT_ENABLE_BYTE}, 0, 8'h00);
    chk_flag(prot_enabled, 1'h1);
    // a mid-run reset stands in for a power cycle
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    tick(3);
    chk_flag(prot_enabled, 1'h0);
    chk_flag(busy, 1'h0);
    e0 = n_er;
    host.frame(32'h7C00_0200, 0, 8'h00);
    chk_val(10'(n_er - e0), 10'h001);
    chk_val({1'h0, erase_mask}, 10'h001);
    wait_idle();
    wrap_up();
  end
endmodule // flash_erase_program_protect_seq_test
